// [tb.sv]
// Self-checking testbench for the status and setup register block
module tb
	import trs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************
	// Signals
	// ****************
	logic        clk_i = 1'b0;
	logic        rst = 1'b1;
	logic        cyc, stb, we, ack, err;
	logic [3:0]  adr, sel;
	logic [31:0] dw, dr, q;
	logic        e;
	logic [5:0]  ev = 6'h0;
	logic        bc = 1'b0;
	logic        rh = 1'b0;
	logic        line = 1'b0;
	logic        quiet = 1'b0;
	logic        nak, frd, enh, ria, rto, srst, irq;
	int          n_errors = 0;
	int          checks = 0;

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	// Busy line keeps the idle and recon timers from expiring
	always @(posedge clk_i) if (!quiet) line <= ~line;

	trs_host_model i_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));

	// Short counts keep the run small
	trs_status_setup #(.IDLE_CNT(20), .MS_CNT(4)) i_dut (
		.clk_i(clk_i), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dw), .dat_o(dr), .ack_o(ack), .err_o(err), .receive_input_i(line),
		.rx_packet_done_i(ev[0]), .rx_attempt_i(ev[1]), .tx_last_byte_i(ev[2]), .tx_acked_i(ev[3]),
		.tx_broadcast_i(bc), .token_rx_i(ev[4]), .node_id_zero_wr_i(ev[5]), .rate_half_i(rh),
		.rx_nak_o(nak), .fast_read_disable_o(frd), .enhanced_timing_o(enh), .ram_init_allow_o(ria),
		.recon_timeout_o(rto), .soft_reset_o(srst), .irq_o(irq));

	// ****************
	// Helpers
	// ****************
	task give_verdict;
		if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	task wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		i_host.xfer(1'b1, a, s, d, q, e);
	endtask

	// Eight-bit registers answer in lane 0
	task rdc(input logic [3:0] a, input logic [31:0] x);
		i_host.xfer(1'b0, a, 4'hf, 32'h0, q, e);
		chk({24'h0, q[7:0]}, x);
	endtask

	// A closed setup register must be refused
	task aux_refused;
		i_host.xfer(1'b0, OFF_AUX_SETUP, 4'hf, 32'h0, q, e);
		chk(e, 1'b1);
	endtask

	task cmd(input logic [3:0] c);
		wr(OFF_COMMAND, 4'h1, {28'h0, c});
	endtask

	task pulse(input int k);
		@(posedge clk_i);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev[k] <= 1'b0;
	endtask

	task mask_irq(input logic [7:0] m, input logic x);
		wr(OFF_COMMAND, 4'h3, {16'h0, m, 8'h0});
		repeat (2) @(posedge clk_i);
		#1;
		chk(irq, x);
	endtask

	// Quiet line until one cycle after the recon pulse; count cycles until the pulse
	task recon(input logic [1:0] s, input int x);
		int n;
		wr(OFF_SUBADDR, 4'h1, 32'h4);
		wr(OFF_AUX_SETUP, 4'h1, {27'h0, s, 3'h0});
		quiet <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (!rto && n < 30000);
		chk(n >= x - 8 && n <= x + 8, 1'b1);
		@(posedge clk_i);
		quiet <= 1'b0;
	endtask

	// Watchdog above the roughly 42k cycles that the tests take
	initial begin
		repeat (60000) @(posedge clk_i);
		n_errors++;
		give_verdict;
	end

	// ****************
	// Tests
	// ****************
	initial begin
		repeat (20) @(posedge clk_i);
		rst <= 1'b0;
		rdc(OFF_STATUS, 32'h91);
		aux_refused;
		wr(OFF_SUBADDR, 4'h1, 32'h4);
		wr(OFF_AUX_SETUP, 4'h1, 32'h7);
		rdc(OFF_AUX_SETUP, 32'h7);
		#1;
		chk(frd, 1'b1);
		chk(enh, 1'b1);
		chk(ria, 1'b1);
		wr(OFF_AUX_SETUP, 4'h1, 32'h0);
		#1;
		chk(frd, 1'b0);
		chk(enh, 1'b0);
		// Busy line and no bypass keep RAM init held off
		chk(ria, 1'b0);
		// Config flag rides in lane 2; lane 0 enables the write
		wr(OFF_COMMAND, 4'h5, 32'h10000);
		aux_refused;
		cmd(CMD_CLEAR_FLAGS);
		rdc(OFF_STATUS, 32'h81);
		pulse(5);
		rdc(OFF_STATUS, 32'h91);
		// Receiver inhibit and refusal of senders
		cmd(CMD_ENABLE_RX);
		rdc(OFF_STATUS, 32'h11);
		pulse(1);
		#1;
		chk(nak, 1'b0);
		pulse(0);
		rdc(OFF_STATUS, 32'h91);
		pulse(1);
		#1;
		chk(nak, 1'b1);
		// Transmit flags, acked, broadcast and disable
		cmd(CMD_ENABLE_TX);
		rdc(OFF_STATUS, 32'h91);
		pulse(4);
		rdc(OFF_STATUS, 32'h90);
		pulse(3);
		pulse(2);
		rdc(OFF_STATUS, 32'h93);
		cmd(CMD_ENABLE_TX);
		pulse(4);
		rdc(OFF_STATUS, 32'h90);
		bc <= 1'b1;
		pulse(3);
		pulse(2);
		rdc(OFF_STATUS, 32'h91);
		bc <= 1'b0;
		cmd(CMD_ENABLE_TX);
		pulse(4);
		cmd(CMD_DISABLE_TX);
		rdc(OFF_STATUS, 32'h91);
		// Masked interrupt sources
		mask_irq(8'h80, 1'b1);
		mask_irq(8'h00, 1'b0);
		mask_irq(8'h01, 1'b1);
		mask_irq(8'h04, 1'b0);
		// Recon periods in clock cycles, four per ms tick, then halved rate
		recon(2'h0, 26880);
		recon(2'h1, 6720);
		recon(2'h2, 3360);
		// Shortest setting: the modelled network is taken to hold node 255
		recon(2'h3, 1680);
		rh <= 1'b1;
		recon(2'h3, 3360);
		rh <= 1'b0;
		#1;
		// Service routine would read the self-caused diagnostic bit next
		chk(irq, 1'b1);
		rdc(OFF_STATUS, 32'h95);
		cmd(CMD_CLEAR_FLAGS);
		rdc(OFF_STATUS, 32'h81);
		// Soft reset keeps setup, hard reset in mid-run
		cmd(CMD_SOFT_RESET);
		// Pulse still stands at the edge that ends the write
		chk(srst, 1'b1);
		repeat (3) @(posedge clk_i);
		rdc(OFF_STATUS, 32'h91);
		wr(OFF_SUBADDR, 4'h1, 32'h4);
		rdc(OFF_AUX_SETUP, 32'h18);
		cmd(CMD_CLEAR_FLAGS);
		rst <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst <= 1'b0;
		rdc(OFF_STATUS, 32'h91);
		give_verdict;
	end
endmodule

// [trs_host_model.sv]
// Host controller model that runs classic single Wishbone cycles
module trs_host_model (
	// Clock
	input  wire logic        clk_i,
	// Slave answer
	input  wire logic        ack_i,
	input  wire logic        err_i,
	input  wire logic [31:0] dat_i,
	// Master request
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [3:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 4'h0;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// One cycle; request held until the edge that samples ack or err
	task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		// Wait for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (!(ack_i || err_i));
		// Answer taken and request released at the edge that sees it
		q = dat_i;
		e = err_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask
endmodule

// [trs_pkg.sv]
// Package: register offsets, field positions, reset values and timing constants for the status/setup block
package trs_pkg;

	// ************************************************************
	// Register map (byte offsets on a 32-bit bus)
	// ************************************************************
	localparam logic [3:0] OFF_STATUS    = 4'h0;
	localparam logic [3:0] OFF_COMMAND   = 4'h4;
	localparam logic [3:0] OFF_SUBADDR   = 4'h8;
	localparam logic [3:0] OFF_AUX_SETUP = 4'hc;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ST_RX_INHIBIT   = 7;
	localparam int ST_RESET_SEEN   = 4;
	localparam int ST_TEST         = 3;
	localparam int ST_RECONFIG     = 2;
	localparam int ST_TX_ACKED     = 1;
	localparam int ST_TX_AVAIL     = 0;
	localparam int AUX_FAST_RD_DIS = 0;
	localparam int AUX_ENH_TIMING  = 1;
	localparam int AUX_IDLE_BYPASS = 2;
	localparam int AUX_RECON_LO    = 3;
	localparam int SUB_SEL2        = 2;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] STATUS_RESET = 8'h91;
	localparam logic [7:0] AUX_RESET    = 8'h00;
	localparam logic [2:0] SUB_RESET    = 3'h0;
	localparam logic [7:0] MASK_RESET   = 8'h00;

	// ************************************************************
	// Host command codes (written to the command register)
	// ************************************************************
	localparam logic [3:0] CMD_CLEAR_FLAGS = 4'h8;
	localparam logic [3:0] CMD_DISABLE_TX  = 4'h1;
	localparam logic [3:0] CMD_ENABLE_TX   = 4'h3;
	localparam logic [3:0] CMD_ENABLE_RX   = 4'h4;
	localparam logic [3:0] CMD_SOFT_RESET  = 4'hf;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ          = 40_000_000;
	localparam int IDLE_TIME_NS    = 656_000;
	localparam int IDLE_CYCLES     = (IDLE_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
	localparam int RECON_T0_MS     = 6720;
	localparam int RECON_T1_MS     = 1680;
	localparam int RECON_T2_MS     = 840;
	localparam int RECON_T3_MS     = 420;
	localparam int CLK_PER_MS      = CLK_HZ / 1000;

endpackage

// [trs_status_setup.sv]
// Status register, auxiliary setup register and timers of the token-ring controller
// Summary of operation
// RULE1 - Setup bit disables fast read path
// RULE2 - Enhanced timing bit clear keeps legacy timing
// RULE3 - RAM init waits idle line unless bypassed
// RULE4 - Two-bit field picks reconfiguration timeout period
// RULE5 - Timeout scales with data rate, nodes unchanged
// RULE6 - Shortest timeout needs a node 255
// RULE7 - Receiver inhibited until enabled, after reception
// RULE8 - Only enable-receive command clears inhibit
// RULE9 - Inhibited receiver answers senders with NAK
// RULE10 - Masked status bits raise interrupt
// RULE11 - Status bits six and five reserved
// RULE12 - Reset or node id zero sets flag
// RULE13 - Test bit reads zero
// RULE14 - Idle line timeout sets reconfiguration flag
// RULE15 - Host checks self-caused reconfig on interrupt
// RULE16 - Acked flag set on ack, cleared by enable
// RULE17 - Broadcasts never report acknowledgement
// RULE18 - Transmitter available on last byte or disable
// RULE19 - Enable transmit clears available at token
// RULE20 - Status resets to 1xx1 0001
// RULE21 - Setup reached via select bit two only
// RULE22 - Interrupt is OR of masked bits
//
// The implementer's own choices: the Wishbone slave port and the address map.
module trs_status_setup
	import trs_pkg::*;
#(
	parameter int IDLE_CNT  = IDLE_CYCLES,
	parameter int MS_CNT    = CLK_PER_MS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	// Network side events from the protocol engine
	input  wire logic        receive_input_i,
	input  wire logic        rx_packet_done_i,
	input  wire logic        rx_attempt_i,
	input  wire logic        tx_last_byte_i,
	input  wire logic        tx_acked_i,
	input  wire logic        tx_broadcast_i,
	input  wire logic        token_rx_i,
	input  wire logic        node_id_zero_wr_i,
	input  wire logic        rate_half_i,
	// Controls to the protocol engine
	output logic             rx_nak_o,
	output logic             fast_read_disable_o,
	output logic             enhanced_timing_o,
	output logic             ram_init_allow_o,
	output logic             recon_timeout_o,
	output logic             soft_reset_o,
	output logic             irq_o
);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Reconfiguration period in ms for a select code
	function automatic logic [12:0] recon_ms(input logic [1:0] s);
		unique case (s)
			2'b00: recon_ms = 13'(RECON_T0_MS);
			2'b01: recon_ms = 13'(RECON_T1_MS);
			2'b10: recon_ms = 13'(RECON_T2_MS);
			2'b11: recon_ms = 13'(RECON_T3_MS);
		endcase
	endfunction

	// ************************************************************
	// Input synchroniser for the line
	// ************************************************************
	logic receive_input_s1_q, receive_input_s2_q, receive_input_prev_q;
	always_ff @(posedge clk_i) begin
		receive_input_s1_q   <= receive_input_i;
		receive_input_s2_q   <= receive_input_s1_q;
		receive_input_prev_q <= receive_input_s2_q;
	end
	wire line_edge = receive_input_s2_q ^ receive_input_prev_q;

	// ************************************************************
	// Registers and bus decode
	// ************************************************************
	logic [7:0]  status_q, status_d;
	logic [7:0]  aux_q, aux_d;
	logic [2:0]  sub_q, sub_d;
	logic [7:0]  mask_q, mask_d;
	logic        tx_pend_q, tx_pend_d;
	logic        ack_q, ack_d;
	logic        err_q, err_d;
	logic [31:0] dat_q, dat_d;
	logic        sreset_q, sreset_d;

	// Writes need lane 0; the mask and the config flag need their own lanes too
	wire req      = cyc_i & stb_i & ~ack_q & ~err_q;
	wire wr       = req & we_i & sel_i[0];
	wire [3:0] cmd = dat_i[3:0];
	wire cmd_wr   = wr && adr_i == OFF_COMMAND;
	wire aux_open = sub_q[SUB_SEL2];
	wire mapped   = adr_i == OFF_STATUS || adr_i == OFF_COMMAND || adr_i == OFF_SUBADDR
		|| (adr_i == OFF_AUX_SETUP && aux_open);          // RULE21

	// Bus answer one cycle after request; unmapped gives err
	always_comb begin
		ack_d = req & mapped;
		err_d = req & ~mapped;
		dat_d = 32'h0;
		unique case (adr_i)
			OFF_STATUS:    dat_d[7:0] = status_q;
			OFF_COMMAND:   dat_d[7:0] = mask_q;
			OFF_SUBADDR:   dat_d[2:0] = sub_q;
			OFF_AUX_SETUP: dat_d[7:0] = aux_open ? aux_q : 8'h00;   // RULE21
			default:       dat_d = 32'h0;
		endcase
	end

	// Control register updates; command low nibble is the opcode, mask sits in bits 15:8
	always_comb begin
		aux_d    = aux_q;
		sub_d    = sub_q;
		mask_d   = mask_q;
		sreset_d = 1'b0;
		if (wr && adr_i == OFF_AUX_SETUP && aux_open)
			aux_d = dat_i[7:0];                                  // RULE1 RULE2 RULE3 RULE4
		if (wr && adr_i == OFF_SUBADDR)
			sub_d = dat_i[2:0];
		if (cmd_wr && sel_i[1])
			mask_d = dat_i[15:8];
		if (cmd_wr && cmd == CMD_SOFT_RESET)
			sreset_d = 1'b1;
		// Configuration write shares the command word (bit 16) and drops the setup select
		if (cmd_wr && sel_i[2] && dat_i[16])
			sub_d[SUB_SEL2] = 1'b0;                              // RULE21
	end

	// ************************************************************
	// Status flags; hardware sets win over command clears
	// ************************************************************
	logic rx_set, recon_set;
	always_comb begin
		status_d  = status_q;
		tx_pend_d = tx_pend_q;
		// Receive inhibit
		if (cmd_wr && cmd == CMD_ENABLE_RX)
			status_d[ST_RX_INHIBIT] = 1'b0;                      // RULE8
		if (rx_set)
			status_d[ST_RX_INHIBIT] = 1'b1;                      // RULE7
		// Reset flag and reconfiguration flag
		if (cmd_wr && cmd == CMD_CLEAR_FLAGS) begin
			status_d[ST_RESET_SEEN] = 1'b0;                      // RULE12
			status_d[ST_RECONFIG]   = 1'b0;                      // RULE14
		end
		if (node_id_zero_wr_i)
			status_d[ST_RESET_SEEN] = 1'b1;                      // RULE12
		if (recon_set)
			status_d[ST_RECONFIG] = 1'b1;                        // RULE14
		// Transmit: enable clears ack now, availability at next token
		if (cmd_wr && cmd == CMD_ENABLE_TX) begin
			status_d[ST_TX_ACKED] = 1'b0;                        // RULE16
			tx_pend_d = 1'b1;
		end
		if (tx_pend_q && token_rx_i) begin
			status_d[ST_TX_AVAIL] = 1'b0;                        // RULE19
			tx_pend_d = 1'b0;
		end
		if (tx_acked_i && !tx_broadcast_i)
			status_d[ST_TX_ACKED] = 1'b1;                        // RULE16 RULE17
		if (tx_last_byte_i || (cmd_wr && cmd == CMD_DISABLE_TX)) begin
			status_d[ST_TX_AVAIL] = 1'b1;                        // RULE18
			tx_pend_d = 1'b0;
		end
		// Reserved and test bits held at zero
		status_d[6:5]     = 2'b00;                               // RULE11
		status_d[ST_TEST] = 1'b0;                                // RULE13
	end
	// A packet only lands in a receiver that is still open
	assign rx_set = rx_packet_done_i & ~status_q[ST_RX_INHIBIT];

	// ************************************************************
	// Line idle timer
	// ************************************************************
	logic [15:0] idle_q, idle_d;
	always_comb begin
		idle_d    = idle_q;
		recon_set = 1'b0;
		if (line_edge)
			idle_d = 16'h0;
		else if (idle_q == 16'(IDLE_CNT - 1)) begin
			idle_d    = 16'h0;
			recon_set = 1'b1;                                    // RULE14
		end else
			idle_d = idle_q + 16'h1;
	end

	// ************************************************************
	// Reconfiguration timer, period doubled at half data rate
	// ************************************************************
	logic [15:0] ms_q, ms_d;
	logic [13:0] rt_q, rt_d;
	logic        rto_d;
	always_comb begin
		ms_d  = ms_q + 16'h1;
		rt_d  = rt_q;
		rto_d = 1'b0;
		if (line_edge) begin
			ms_d = 16'h0;
			rt_d = 14'h0;
		end else if (ms_q == 16'(MS_CNT - 1)) begin
			ms_d = 16'h0;
			// Scaling the limit keeps node count per setting unchanged
			if (rt_q == (rate_half_i ? {recon_ms(aux_q[AUX_RECON_LO +: 2]), 1'b0}
				: {1'b0, recon_ms(aux_q[AUX_RECON_LO +: 2])}) - 14'h1) begin   // RULE4 RULE5
				rt_d  = 14'h0;
				rto_d = 1'b1;
			end else
				rt_d = rt_q + 14'h1;
		end
	end

	// ************************************************************
	// State registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || sreset_q) begin
			status_q <= STATUS_RESET;                            // RULE20 RULE12
			tx_pend_q <= 1'b0;
			idle_q <= 16'h0;
			ms_q <= 16'h0;
			rt_q <= 14'h0;
			recon_timeout_o <= 1'b0;
			rx_nak_o <= 1'b0;
			irq_o <= 1'b0;
			fast_read_disable_o <= 1'b0;
			enhanced_timing_o <= 1'b0;
			ram_init_allow_o <= 1'b0;
		end else begin
			status_q <= status_d;
			tx_pend_q <= tx_pend_d;
			idle_q <= idle_d;
			ms_q <= ms_d;
			rt_q <= rt_d;
			recon_timeout_o <= rto_d;
			// NAK follows the flag as it stands, not its next value
			rx_nak_o <= rx_attempt_i & status_q[ST_RX_INHIBIT];                    // RULE9
			irq_o <= |(status_d & mask_q);                                         // RULE10 RULE22
			fast_read_disable_o <= aux_q[AUX_FAST_RD_DIS];                         // RULE1
			enhanced_timing_o <= aux_q[AUX_ENH_TIMING];                            // RULE2
			ram_init_allow_o <= aux_q[AUX_IDLE_BYPASS] | (~line_edge & idle_q != 16'h0);  // RULE3
		end
	end

	// Bus and configuration registers survive soft reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_q <= AUX_RESET;
			sub_q <= SUB_RESET;
			mask_q <= MASK_RESET;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= 32'h0;
			sreset_q <= 1'b0;
		end else begin
			aux_q <= aux_d;
			sub_q <= sub_d;
			mask_q <= mask_d;
			ack_q <= ack_d;
			err_q <= err_d;
			dat_q <= dat_d;
			sreset_q <= sreset_d;
		end
	end
	// Bus outputs come straight from their registers
	assign ack_o = ack_q;
	assign err_o = err_q;
	assign dat_o = dat_q;
	assign soft_reset_o = sreset_q;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_rx_clear;
		@(posedge clk_i) disable iff (rst_i || sreset_q)
		$fell(status_q[ST_RX_INHIBIT]) |-> $past(cmd_wr && cmd == CMD_ENABLE_RX);
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("inhibit cleared without enable");  // RULE8

	// Any attempt seen while inhibited is refused in the next cycle
	property p_nak;
		@(posedge clk_i) disable iff (rst_i || sreset_q)
		(rx_attempt_i && status_q[ST_RX_INHIBIT]) |=> rx_nak_o;
	endproperty
	a_nak: assert property (p_nak) else $error("no NAK while inhibited");  // RULE9

	// Reset cycles force irq low, so only cycles run in normal mode are compared
	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && !sreset_q |=> irq_o == |($past(status_d) & $past(mask_q));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt mismatch");  // RULE22

	property p_rsv;
		@(posedge clk_i) disable iff (rst_i)
		status_q[6:5] == 2'b00 && !status_q[ST_TEST];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved or test bit set");  // RULE13

	property p_reset_val;
		@(posedge clk_i) $rose(rst_i) ##1 rst_i |-> status_q == STATUS_RESET;
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("bad status reset value");  // RULE20

	property p_bcast;
		@(posedge clk_i) disable iff (rst_i || sreset_q)
		$rose(status_q[ST_TX_ACKED]) |-> $past(tx_acked_i && !tx_broadcast_i);
	endproperty
	a_bcast: assert property (p_bcast) else $error("ack reported for broadcast");  // RULE17

	property p_avail;
		@(posedge clk_i) disable iff (rst_i || sreset_q)
		tx_last_byte_i |=> status_q[ST_TX_AVAIL];
	endproperty
	a_avail: assert property (p_avail) else $error("available not set");  // RULE18

	property p_recon;
		@(posedge clk_i) disable iff (rst_i || sreset_q)
		recon_set |=> status_q[ST_RECONFIG];
	endproperty
	a_recon: assert property (p_recon) else $error("reconfig flag not set");  // RULE14

	property p_sel;
		@(posedge clk_i) disable iff (rst_i)
		(req && adr_i == OFF_AUX_SETUP && !aux_open) |=> err_o && !ack_o;
	endproperty
	a_sel: assert property (p_sel) else $error("setup reachable without select");  // RULE21

endmodule
